// *** rtl/dsc_regs.sv ***
// wishbone register bank for virtual network, sense amps and comparator filter
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - reserved bits read zero, read-only
// - phase bit 6 enables resistor network
// - phase bit 5 routes neutral to DAC
// - phase bit 4 routes neutral to pin
// - phase bits 2..0 switch taps
// - sense bit 2 enables amplifier A
// - sense bit 0 enables amplifier B
// - filter count needs that many agreeing samples
// - count one passes each sample
// - count zero bypasses, low when sampling
// - filter bit 0 selects hysteresis level
module dsc_regs
   import dsc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [17:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             err_o,
   // analog controls
   output logic             resistor_network_enable_o,
   output logic             neutral_internal_route_o,
   output logic             neutral_external_route_o,
   output logic [2:0]       phase_tap_on_o,
   output logic             sense_amp_a_enable_o,
   output logic             sense_amp_b_enable_o,
   output logic             hysteresis_level_o,
   // comparator
   input  wire logic        raw_compare_out_i,
   output logic             filtered_compare_out_o
);
   import dsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0] phase_reg;    // phase control
   logic [7:0] cursns_reg;   // sense amp control
   logic [7:0] filter_reg;   // filter control
   logic [7:0] sample_reg;   // sampling mode control
   logic       raw_sync;     // synchronised comparator
   logic       filt_out;     // filter output
   logic [15:0] idx;         // word index
   logic       req;          // new bus request
   logic       hit;          // mapped address
   logic [7:0] rd_next;      // read data

   // mask per register, used by read and write decode
   function automatic logic [7:0] dsc_mask(input logic [15:0] a);
      case (a)
         DSC_IDX_PHASE:  dsc_mask = DSC_PH_MASK;
         DSC_IDX_CURSNS: dsc_mask = DSC_CS_MASK;
         DSC_IDX_FILTER: dsc_mask = DSC_FL_MASK;
         DSC_IDX_SAMPLE: dsc_mask = DSC_SM_MASK;
         default:        dsc_mask = 8'h00;
      endcase
   endfunction : dsc_mask

   assign idx = adr_i[17:2];
   // one answer per request; ack drops in the cycle after
   assign req = cyc_i & stb_i & ~ack_o & ~err_o;
   assign hit = (idx == DSC_IDX_PHASE) || (idx == DSC_IDX_CURSNS) ||
                (idx == DSC_IDX_FILTER) || (idx == DSC_IDX_SAMPLE) ||
                (idx == DSC_IDX_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // writes, byte lane 0 only carries data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_reg  <= DSC_RST_VAL;
         cursns_reg <= DSC_RST_VAL;
         filter_reg <= DSC_RST_VAL;
         sample_reg <= DSC_RST_VAL;
      end else if (req && we_i && sel_i[0]) begin
         // reserved positions masked off at store
         case (idx)
            DSC_IDX_PHASE:  phase_reg  <= dat_i[7:0] & dsc_mask(idx);
            DSC_IDX_CURSNS: cursns_reg <= dat_i[7:0] & dsc_mask(idx);
            DSC_IDX_FILTER: filter_reg <= dat_i[7:0] & dsc_mask(idx);
            DSC_IDX_SAMPLE: sample_reg <= dat_i[7:0] & dsc_mask(idx);
            default: ;      // status and unmapped: no store
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; reserved bits are zero since never stored
   always_comb begin
      case (idx)
         DSC_IDX_PHASE:  rd_next = phase_reg & dsc_mask(idx);
         DSC_IDX_CURSNS: rd_next = cursns_reg & dsc_mask(idx);
         DSC_IDX_FILTER: rd_next = filter_reg & dsc_mask(idx);
         DSC_IDX_SAMPLE: rd_next = sample_reg & dsc_mask(idx);
         DSC_IDX_STATUS: rd_next = {6'h00, raw_sync, filt_out};
         default:        rd_next = 8'h00;
      endcase
   end

   // answer one cycle after request; unmapped gets err
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req & hit;
         err_o <= req & ~hit;
         dat_o <= {24'h00_0000, (req && hit && !we_i) ? rd_next : 8'h00};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control outputs from flops, one cycle behind storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resistor_network_enable_o <= 1'b0;
         neutral_internal_route_o  <= 1'b0;
         neutral_external_route_o  <= 1'b0;
         phase_tap_on_o            <= 3'h0;
         sense_amp_a_enable_o      <= 1'b0;
         sense_amp_b_enable_o      <= 1'b0;
         hysteresis_level_o        <= 1'b0;
         filtered_compare_out_o    <= 1'b0;
      end else begin
         resistor_network_enable_o <= phase_reg[DSC_PH_NET_BIT];
         neutral_internal_route_o  <= phase_reg[DSC_PH_INT_BIT];
         neutral_external_route_o  <= phase_reg[DSC_PH_EXT_BIT];
         phase_tap_on_o            <= phase_reg[DSC_PH_TAP0_BIT +: 3];
         sense_amp_a_enable_o      <= cursns_reg[DSC_CS_AMPA_BIT];
         sense_amp_b_enable_o      <= cursns_reg[DSC_CS_AMPB_BIT];
         hysteresis_level_o        <= filter_reg[DSC_FL_HYSTERESIS_LEVEL_BIT];
         filtered_compare_out_o    <= filt_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparator path: pin level synchronised, then filtered
   dsc_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (raw_compare_out_i),
      .q_o   (raw_sync)
   );

   // sampling mode is expected clear; set forces bypass output low
   dsc_filter u_filter (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .count_i     (filter_reg[DSC_FL_CNT_LSB +: 3]),
      .sample_en_i (sample_reg[DSC_SM_EN_BIT]),
      .raw_i       (raw_sync),
      .out_o       (filt_out)
   );

endmodule : dsc_regs

// *** rtl/dsc_pkg.sv ***
// package of offsets, field positions and reset values for the sense control bank
package dsc_pkg;

   // register indices as printed (byte address is four times the index)
   localparam logic [15:0] DSC_IDX_PHASE   = 16'h1872;   // phase control
   localparam logic [15:0] DSC_IDX_CURSNS  = 16'h1873;   // sense amp control
   localparam logic [15:0] DSC_IDX_FILTER  = 16'h1874;   // limit comparator filter
   // sampling mode control, own word after the filter register
   localparam logic [15:0] DSC_IDX_SAMPLE  = 16'h1875;
   // comparator status word, own choice
   localparam logic [15:0] DSC_IDX_STATUS  = 16'h1876;

   // phase control fields
   localparam int DSC_PH_NET_BIT  = 6;
   localparam int DSC_PH_INT_BIT  = 5;
   localparam int DSC_PH_EXT_BIT  = 4;
   localparam int DSC_PH_TAP0_BIT = 0;
   localparam logic [7:0] DSC_PH_MASK = 8'h77;

   // sense amp fields
   localparam int DSC_CS_AMPA_BIT = 2;
   localparam int DSC_CS_AMPB_BIT = 0;
   localparam logic [7:0] DSC_CS_MASK = 8'h05;

   // filter fields
   localparam int DSC_FL_CNT_LSB  = 4;
   localparam int DSC_FL_HYSTERESIS_LEVEL_BIT = 0;
   localparam logic [7:0] DSC_FL_MASK = 8'h71;

   // sampling mode field
   localparam int DSC_SM_EN_BIT   = 7;
   localparam logic [7:0] DSC_SM_MASK = 8'h80;

   // reset values
   localparam logic [7:0] DSC_RST_VAL = 8'h00;

   // filter code that bypasses the filter
   localparam logic [2:0] DSC_FL_BYPASS = 3'h0;

   // filter state machine
   typedef enum logic [1:0] {
      DSC_FS_IDLE  = 2'b00,
      DSC_FS_TRACK = 2'b01,
      DSC_FS_HOLD  = 2'b11
   } dsc_fstate_t;

endpackage : dsc_pkg

// *** rtl/dsc_sync.sv ***
// two flip-flop synchroniser for the raw comparator level
`timescale 1ns/1ps
module dsc_sync (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // level in and out
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_reg;   // first stage, read only by second stage

   // plain double flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= 1'b0;
         q_o      <= 1'b0;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule : dsc_sync

// *** rtl/dsc_filter.sv ***
// consecutive-sample output filter for the limit comparator
`timescale 1ns/1ps
module dsc_filter
   import dsc_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // settings
   input  wire logic [2:0] count_i,
   input  wire logic       sample_en_i,
   // comparator in and filtered out
   input  wire logic       raw_i,
   output logic            out_o
);
   dsc_fstate_t state_reg;     // tracking state
   logic [2:0]  agree_reg;     // samples that agree so far
   logic        cand_reg;      // candidate new level

   // filter: one sample per clock, output follows after count agreeing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= DSC_FS_IDLE;
         agree_reg <= 3'h0;
         cand_reg  <= 1'b0;
         out_o     <= 1'b0;
      end else if (count_i == DSC_FL_BYPASS) begin
         // bypass: raw level, or forced low in sampling mode
         state_reg <= DSC_FS_IDLE;
         agree_reg <= 3'h0;
         out_o     <= sample_en_i ? 1'b0 : raw_i;
      end else begin
         case (state_reg)
            DSC_FS_IDLE: begin
               if (raw_i != out_o) begin
                  if (count_i == 3'h1) begin
                     out_o <= raw_i;
                  end else begin
                     cand_reg  <= raw_i;
                     agree_reg <= 3'h1;
                     state_reg <= DSC_FS_TRACK;
                  end
               end
            end
            DSC_FS_TRACK: begin
               if (raw_i != cand_reg) begin
                  // disagreement restarts the count
                  state_reg <= DSC_FS_IDLE;
               end else if (agree_reg + 3'h1 >= count_i) begin
                  out_o     <= cand_reg;
                  state_reg <= DSC_FS_HOLD;
               end else begin
                  agree_reg <= agree_reg + 3'h1;
               end
            end
            DSC_FS_HOLD: state_reg <= DSC_FS_IDLE;  // one settle cycle
            default:     state_reg <= DSC_FS_IDLE;
         endcase
      end
   end
endmodule : dsc_filter

// *** sim/dsc_regs_checker.sv ***
// checker of bus timing and control outputs for the sense control bank
`timescale 1ns/1ps
module dsc_regs_checker
   import dsc_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [17:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic        resistor_network_enable_o,
   input wire logic        neutral_internal_route_o,
   input wire logic        neutral_external_route_o,
   input wire logic [2:0]  phase_tap_on_o,
   input wire logic        sense_amp_a_enable_o,
   input wire logic        sense_amp_b_enable_o,
   input wire logic        hysteresis_level_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic tk;  // request taken at this edge
   logic wr0; // storing write taken
   assign tk = cyc_i && stb_i && !ack_o && !err_o;
   assign wr0 = tk && we_i && sel_i[0];
   ////////////////////////////////////////////////////////////////////////////////
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
   a_err_pulse: assert property (err_o |=> !err_o) else $error("err held too long");
   a_idle_data: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   a_answer_next: assert property (tk |=> ack_o ^ err_o) else $error("no single answer");
   a_unmapped_err: assert property (tk && (adr_i[17:2] < DSC_IDX_PHASE ||
      adr_i[17:2] > DSC_IDX_STATUS) |=> err_o) else $error("unmapped without err");
   a_high_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   a_phase_rsvd: assert property (ack_o && !we_i && adr_i[17:2] == DSC_IDX_PHASE
      |-> (dat_o[7:0] & ~DSC_PH_MASK) == 8'h00) else $error("phase reserved bit set");
   a_phase_write: assert property (wr0 && adr_i[17:2] == DSC_IDX_PHASE |=> ##1
      {resistor_network_enable_o, neutral_internal_route_o, neutral_external_route_o,
      phase_tap_on_o} == {$past(dat_i[6:4], 2), $past(dat_i[2:0], 2)})
      else $error("phase outputs wrong");
   a_sense_write: assert property (wr0 && adr_i[17:2] == DSC_IDX_CURSNS |=> ##1
      {sense_amp_a_enable_o, sense_amp_b_enable_o} == {$past(dat_i[2], 2), $past(dat_i[0], 2)})
      else $error("sense outputs wrong");
   a_hysteresis_level_write: assert property (wr0 && adr_i[17:2] == DSC_IDX_FILTER |=> ##1
      hysteresis_level_o == $past(dat_i[0], 2)) else $error("hysteresis output wrong");
   a_hysteresis_level_quiet: assert property ($changed(hysteresis_level_o) |-> $past(ack_o))
      else $error("hysteresis moved without write");
   // main scenarios reached
   c_phase_wr: cover property (wr0 && adr_i[17:2] == DSC_IDX_PHASE);
   c_err: cover property (err_o);
   c_read: cover property (ack_o && !we_i);
endmodule : dsc_regs_checker
bind dsc_regs dsc_regs_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
   .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .resistor_network_enable_o,
   .neutral_internal_route_o, .neutral_external_route_o, .phase_tap_on_o,
   .sense_amp_a_enable_o, .sense_amp_b_enable_o, .hysteresis_level_o);

// *** sim/test_driver_sense_control_regs.sv ***
// self-checking bench for the sense control register bank
`timescale 1ns/1ps
module test_driver_sense_control_regs;
   import dsc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1;            // clock, sync reset
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0; // bus strobes
   logic [17:0] adr_i = 18'h0;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic ack_o, err_o, e, seen, raw_compare_out_i = 1'b0, filtered_compare_out_o;
   logic resistor_network_enable_o, neutral_internal_route_o, neutral_external_route_o;
   logic sense_amp_a_enable_o, sense_amp_b_enable_o, hysteresis_level_o;
   logic [2:0]  phase_tap_on_o;
   logic [7:0]  d, sh [3];                        // shadow of stored values
   logic [15:0] idx [3] = '{DSC_IDX_PHASE, DSC_IDX_CURSNS, DSC_IDX_FILTER};
   logic [7:0]  msk [3] = '{DSC_PH_MASK, DSC_CS_MASK, DSC_FL_MASK};
   int err_total = 0, checks = 0, cyc_n = 0, i, n, g, k;
   integer seed = 30821;
   dsc_regs dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .err_o, .resistor_network_enable_o, .neutral_internal_route_o,
      .neutral_external_route_o, .phase_tap_on_o, .sense_amp_a_enable_o,
      .sense_amp_b_enable_o, .hysteresis_level_o, .raw_compare_out_i, .filtered_compare_out_o);
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      checks++;
      if (y !== x) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, x, y);
      end
   endtask : chk
   // classic cycle, held until ack or err is sampled
   task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] v, input logic s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {a, 2'b00};
      sel_i <= {3'h0, s};
      dat_i <= {24'h0, v};
      do @(posedge clk_i); while (!(ack_o === 1'b1 || err_o === 1'b1));
      q = dat_o;
      e = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask : wb
   function automatic logic [8:0] exp_ctl(input logic [7:0] p, c, f);
      return {p[6:4], p[2:0], c[2], c[0], f[0]};
   endfunction : exp_ctl
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // hang guard, well above the expected run
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         err_total++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 3; i++) begin
         wb(1'b0, idx[i], 8'h00, 1'b1);
         chk("reset value", 32'h0, q);
         sh[i] = 8'h00;
      end
      $display("reset test done");
      // random writes, sel bit random so some must not store
      for (n = 0; n < 30; n++) begin
         i = $unsigned($random(seed)) % 3;
         d = (n < 3) ? 8'hff : 8'($random(seed));
         k = (n < 3) ? 1 : $random(seed) & 1;
         wb(1'b1, idx[i], d, k[0]);
         if (k[0]) sh[i] = d & msk[i];
         wb(1'b0, idx[i], 8'h00, 1'b1);
         chk("readback", {24'h0, sh[i]}, q);
         chk("controls", exp_ctl(sh[0], sh[1], sh[2]), {resistor_network_enable_o,
            neutral_internal_route_o, neutral_external_route_o, phase_tap_on_o,
            sense_amp_a_enable_o, sense_amp_b_enable_o, hysteresis_level_o});
      end
      wb(1'b1, 16'h1877, 8'hff, 1'b1);
      chk("unmapped err", 32'h1, e);
      $display("register test done");
      // glitch of n-1 samples is absorbed; counts 0 and 1 pass a single sample
      for (n = 0; n < 8; n++) begin
         wb(1'b1, DSC_IDX_FILTER, {1'b0, n[2:0], 4'h0}, 1'b1);
         raw_compare_out_i <= 1'b0;
         repeat (20) @(posedge clk_i);
         chk("filter low", 32'h0, filtered_compare_out_o);
         g = (n > 1) ? n - 1 : 1;
         seen = 1'b0;
         raw_compare_out_i <= 1'b1;
         for (k = 0; k < g + 15; k++) begin
            @(posedge clk_i);
            if (k == g - 1) raw_compare_out_i <= 1'b0;
            if (filtered_compare_out_o === 1'b1) seen = 1'b1;
         end
         chk("glitch pass", 32'(n < 2), seen);
         raw_compare_out_i <= 1'b1;
         repeat (n + 8) @(posedge clk_i);
         chk("filter high", 32'h1, filtered_compare_out_o);
      end
      $display("filter test done");
      wb(1'b1, DSC_IDX_FILTER, 8'h00, 1'b1);
      wb(1'b1, DSC_IDX_SAMPLE, 8'h80, 1'b1);
      repeat (10) @(posedge clk_i);
      chk("sampled bypass", 32'h0, filtered_compare_out_o);
      wb(1'b1, DSC_IDX_SAMPLE, 8'hff, 1'b1);
      wb(1'b0, DSC_IDX_SAMPLE, 8'h00, 1'b1);
      chk("sample readback", {24'h0, DSC_SM_MASK}, q);
      wb(1'b0, DSC_IDX_STATUS, 8'h00, 1'b1);
      chk("status word", 32'h2, q);
      wb(1'b1, DSC_IDX_SAMPLE, 8'h00, 1'b1);
      $display("bypass test done");
      final_report();
   end
endmodule : test_driver_sense_control_regs
